//--- core/sesl_core.sv
// Purpose: serial memory with eight programmable switch terminals
// Assumes: link wires come from another domain and are oversampled
// Notes: one instruction at a time; new starts wait while busy

`timescale 1ns/1ps
`default_nettype none

module sesl_core (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire sesl_pkg::sesl_link_s link,
	input  wire sesl_pkg::sesl_term_s termIn,
	output var  logic                 dataOut,
	output var  sesl_pkg::sesl_term_s termOut,
	output var  sesl_pkg::sesl_term_s termOe,
	output var  logic [3:0]           anaClosed
);

	// terminal pair decode: {closed, aOe, aOut, bOe, bOut}
	function automatic logic [4:0] pairDrive(input logic [3:0] code, input logic aLev);
		logic [4:0] r;
		r = 5'h00;
		if (code[3:2] == sesl_pkg::MODE_LVL) begin
			r = {1'b0, 1'b1, code[1], 1'b1, code[0]}; // fixed levels
		end else if (code == sesl_pkg::MODE_DEB) begin
			r = {1'b0, 1'b0, 1'b0, ~aLev, 1'b0}; // key low pulls b low
		end else if (code[3:1] == sesl_pkg::MODE_CLOSED) begin
			r = 5'h10; // analog switch closed
		end
		return r;
	endfunction

	// synchroniser stages and filtered levels
	logic [10:0] syncA;    // first stage, read by syncB only
	logic [10:0] syncB;    // second stage
	logic [10:0] syncC;    // third stage
	logic [10:0] lev;      // accepted levels
	logic        skPrev;   // last accepted serial clock

	// serial engine state
	sesl_pkg::sesl_state_e state;      // current step
	sesl_pkg::sesl_state_e next_state; // step after this edge
	logic [4:0]  bitCnt;   // bits seen in this step
	logic [7:0]  cmdReg;   // opcode and address
	logic [15:0] shiftIn;  // write data
	logic [15:0] shiftOut; // read data
	logic        progEn;   // programming enabled
	logic [15:0] switch_control_word;      // switch_control_word
	logic        next_dataOut;

	// programming cycle
	logic [11:0] progCnt;  // cycles left
	logic        walkOn;   // write-all walk running
	logic [5:0]  walkAddr; // walk position

	// memory ports
	logic [15:0] memRdata;

	// raw pins into the synchroniser
	wire [10:0] rawIn = {termIn, link.sk, link.cs, link.di};

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge clock) begin
		if (rst) begin
			syncA <= sesl_pkg::SYNC_IDLE;
			syncB <= sesl_pkg::SYNC_IDLE;
			syncC <= sesl_pkg::SYNC_IDLE;
		end else begin
			syncA <= rawIn;
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	// accept a level only when it has stood for two samples
	wire [10:0] agree   = ~(syncB ^ syncC);
	wire [10:0] nextLev = (agree & syncB) | (~agree & lev);

	always_ff @(posedge clock) begin
		if (rst) begin
			lev    <= sesl_pkg::SYNC_IDLE; // no false key press after reset
			skPrev <= 1'b0;
		end else begin
			lev    <= nextLev;
			skPrev <= lev[sesl_pkg::SYNC_SK];
		end
	end

	// named levels and edges
	wire       diLev   = lev[sesl_pkg::SYNC_DI];
	wire       csLev   = lev[sesl_pkg::SYNC_CS];
	wire       skRise  = lev[sesl_pkg::SYNC_SK] & ~skPrev;
	wire [7:0] termLev = lev[10:3];
	wire       busy    = progCnt != 12'h000;
	wire       booting = (state == sesl_pkg::ST_BOOT) || (state == sesl_pkg::ST_BOOTLD);

	// command decode; on the eighth rise the last address bit is still on the wire,
	// so the byte is sorted from the value the shift register is about to take
	wire       cmdDone  = (state == sesl_pkg::ST_CMD) && skRise && (bitCnt == sesl_pkg::CMD_LAST);
	wire [7:0] cmdSeen  = cmdDone ? {cmdReg[6:0], diLev} : cmdReg;
	wire [1:0] cmdOp    = cmdSeen[7:6];
	wire [5:0] cmdAddr  = cmdSeen[5:0];
	wire       isExt    = cmdOp == sesl_pkg::OP_EXT;
	wire       extAll   = isExt && (cmdAddr[5:4] == sesl_pkg::EXT_ALL);
	wire       needData = (cmdOp == sesl_pkg::OP_WRITE) || extAll;
	wire       isRead   = cmdOp == sesl_pkg::OP_READ;
	wire       isNvAddr = cmdAddr <= sesl_pkg::ADDR_ISS;
	wire       commit   = state == sesl_pkg::ST_COMMIT;
	wire       startBit = csLev && skRise && diLev && !busy;
	wire       dinDone  = (state == sesl_pkg::ST_DIN) && skRise && (bitCnt == sesl_pkg::DATA_LAST);
	wire       doutDone = (state == sesl_pkg::ST_DOUT) && skRise && (bitCnt == sesl_pkg::DATA_LAST);

	// write strobes
	wire wrWord = commit && (cmdOp == sesl_pkg::OP_WRITE);
	wire wrNv   = wrWord && isNvAddr && progEn;
	wire wrScw  = wrWord && (cmdAddr == sesl_pkg::ADDR_SCW);
	wire write_all_cmd  = commit && extAll && progEn;
	wire setEn  = commit && isExt && (cmdAddr[5:4] == sesl_pkg::EXT_EN);
	wire clrEn  = commit && isExt && (cmdAddr[5:4] == sesl_pkg::EXT_DIS);

	// memory port selection
	wire        memWe    = wrNv | walkOn;
	wire [5:0]  memWaddr = walkOn ? walkAddr : cmdAddr;
	wire [5:0]  memRaddr = (state == sesl_pkg::ST_BOOT) ? sesl_pkg::ADDR_ISS : cmdAddr;

	// read source: control word, live levels or the array
	wire [15:0] readWord = (cmdAddr == sesl_pkg::ADDR_SCW) ? switch_control_word :
		(cmdAddr == sesl_pkg::ADDR_SRW) ? {8'h00, termLev} : memRdata;

	// 64 x 16 array, 1K bits
	sesl_nv_store u_store (
		.clock (clock),
		.we    (memWe),
		.waddr (memWaddr),
		.wdata (shiftIn),
		.raddr (memRaddr),
		.rdata (memRdata)
	);

	// next step of the serial engine
	always_comb begin
		next_state = state;
		case (state)
			sesl_pkg::ST_BOOT:   next_state = sesl_pkg::ST_BOOTLD;
			sesl_pkg::ST_BOOTLD: next_state = sesl_pkg::ST_IDLE;
			sesl_pkg::ST_IDLE: begin
				if (startBit) begin
					next_state = sesl_pkg::ST_CMD;
				end
			end
			sesl_pkg::ST_CMD: begin
				if (cmdDone) begin
					next_state = sesl_pkg::ST_COMMIT;
				end
			end
			sesl_pkg::ST_DIN: begin
				if (dinDone) begin
					next_state = sesl_pkg::ST_COMMIT;
				end
			end
			sesl_pkg::ST_COMMIT: next_state = sesl_pkg::ST_IDLE;
			sesl_pkg::ST_RDSEL:  next_state = sesl_pkg::ST_RDLOAD;
			sesl_pkg::ST_RDLOAD: next_state = sesl_pkg::ST_DOUT;
			sesl_pkg::ST_DOUT: begin
				if (doutDone) begin
					next_state = sesl_pkg::ST_DONE;
				end
			end
			sesl_pkg::ST_DONE: next_state = sesl_pkg::ST_DONE;
			default:           next_state = sesl_pkg::ST_IDLE;
		endcase
		// command byte sorts itself after the eighth bit
		if (cmdDone) begin
			if (isRead) begin
				next_state = sesl_pkg::ST_RDSEL;
			end else if (needData) begin
				next_state = sesl_pkg::ST_DIN;
			end
		end
		// select low abandons whatever was under way, save boot and commit
		if (!csLev && !booting && !commit) begin
			next_state = sesl_pkg::ST_IDLE;
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= sesl_pkg::ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// bit counter restarts on every change of step
	always_ff @(posedge clock) begin
		if (rst || (next_state != state)) begin
			bitCnt <= 5'h00;
		end else if (skRise) begin
			bitCnt <= bitCnt + 5'h01;
		end
	end

	// command and write data shift in msb first
	always_ff @(posedge clock) begin
		if (rst) begin
			cmdReg  <= 8'h00;
			shiftIn <= 16'h0000;
		end else if (skRise && (state == sesl_pkg::ST_CMD)) begin
			cmdReg <= {cmdReg[6:0], diLev};
		end else if (skRise && (state == sesl_pkg::ST_DIN)) begin
			shiftIn <= {shiftIn[14:0], diLev};
		end
	end

	// read data: loaded once, then shifted per serial clock
	always_ff @(posedge clock) begin
		if (rst) begin
			shiftOut <= 16'h0000;
		end else if (state == sesl_pkg::ST_RDLOAD) begin
			shiftOut <= readWord;
		end else if (skRise && (state == sesl_pkg::ST_DOUT)) begin
			shiftOut <= {shiftOut[14:0], 1'b0};
		end
	end

	// data out: ready flag when idle, dummy zero, then data bits
	always_comb begin
		next_dataOut = dataOut;
		case (state)
			sesl_pkg::ST_IDLE:   next_dataOut = csLev && !busy;
			sesl_pkg::ST_RDLOAD: next_dataOut = 1'b0;
			sesl_pkg::ST_DOUT: begin
				if (skRise) begin
					next_dataOut = shiftOut[15];
				end
			end
			sesl_pkg::ST_DONE:   next_dataOut = dataOut;
			default:             next_dataOut = dataOut;
		endcase
		if (!csLev) begin
			next_dataOut = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dataOut <= 1'b0;
		end else begin
			dataOut <= next_dataOut;
		end
	end

	// programming enable; off at power-up so stray writes are lost
	always_ff @(posedge clock) begin
		if (rst || clrEn) begin
			progEn <= 1'b0;
		end else if (setEn) begin
			progEn <= 1'b1;
		end
	end

	// programming cycle length; new instructions wait while it runs
	always_ff @(posedge clock) begin
		if (rst) begin
			progCnt <= 12'h000;
		end else if (wrNv || write_all_cmd) begin
			progCnt <= sesl_pkg::PROG_COUNT;
		end else if (busy) begin
			progCnt <= progCnt - 12'h001;
		end
	end

	// write-all walks one word per cycle, well inside the busy time
	always_ff @(posedge clock) begin
		if (rst) begin
			walkOn   <= 1'b0;
			walkAddr <= 6'h00;
		end else if (write_all_cmd) begin
			walkOn   <= 1'b1;
			walkAddr <= 6'h00;
		end else if (walkOn) begin
			walkOn   <= walkAddr != sesl_pkg::ADDR_ISS;
			walkAddr <= walkAddr + 6'h01;
		end
	end

	// control word: copied from the array at power-up, volatile after
	always_ff @(posedge clock) begin
		if (rst) begin
			switch_control_word <= sesl_pkg::SCW_RESET;
		end else if (state == sesl_pkg::ST_BOOTLD) begin
			switch_control_word <= memRdata;
		end else if (wrScw) begin
			switch_control_word <= shiftIn;
		end
	end

	// per-pair drive from the control word
	logic [4:0] pairNext [4];
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pair
			assign pairNext[gi] = pairDrive(switch_control_word[4*gi+3 -: 4], termLev[gi]);
		end
	endgenerate

	// terminal registers; released until a mode asks to drive
	always_ff @(posedge clock) begin
		if (rst) begin
			termOut   <= '0;
			termOe    <= '0;
			anaClosed <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				anaClosed[i] <= pairNext[i][4];
				termOe.a[i]  <= pairNext[i][3];
				termOut.a[i] <= pairNext[i][2];
				termOe.b[i]  <= pairNext[i][1];
				termOut.b[i] <= pairNext[i][0];
			end
		end
	end

	// checks on the engine and terminals
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	selectDrop_a: assert property (
		(!csLev && !booting && !commit) |=> state == sesl_pkg::ST_IDLE)
		else $error("select low did not return to idle");

	lockedWrite_a: assert property (
		(commit && !progEn) |-> !memWe)
		else $error("array written while programming disabled");

	writeAll_a: assert property (
		write_all_cmd |=> (memWe && memWaddr == 6'h00) ##1 memWe [*7])
		else $error("write-all walk did not run");

	bootCopy_a: assert property (
		(state == sesl_pkg::ST_BOOTLD) |=>
		(switch_control_word == $past(memRdata)) && ($past(memRaddr, 2) == sesl_pkg::ADDR_ISS))
		else $error("control word not loaded from location 61");

	scwWrite_a: assert property (
		wrScw |=> (switch_control_word == $past(shiftIn)) && !busy && !memWe)
		else $error("control word write wrong or started programming");

	readbackLive_a: assert property (
		(state == sesl_pkg::ST_RDLOAD && cmdAddr == sesl_pkg::ADDR_SRW) |=>
		shiftOut == {8'h00, $past(termLev)})
		else $error("readback did not return terminal levels");

	readbackWrite_a: assert property (
		(commit && cmdAddr == sesl_pkg::ADDR_SRW) |=> $stable(switch_control_word) && !memWe)
		else $error("write to readback location changed state");

	pairHigh_a: assert property (
		(switch_control_word[15:12] == 4'h3) |=>
		termOut.a[3] && termOut.b[3] && termOe.a[3] && termOe.b[3])
		else $error("mode 0011 did not drive both outputs high");

	switchOpen_a: assert property (
		(switch_control_word[3:1] == sesl_pkg::MODE_OPEN) |=> !anaClosed[0] && !termOe.a[0])
		else $error("analog switch not held open");

	switchShut_a: assert property (
		(switch_control_word[3:1] == sesl_pkg::MODE_CLOSED) |=> anaClosed[0] && !termOe.b[0])
		else $error("analog switch not held closed");

	keyIrq_a: assert property (
		(switch_control_word[7:4] == sesl_pkg::MODE_DEB && !termLev[1]) |=>
		termOe.b[1] && !termOut.b[1] && !termOe.a[1])
		else $error("pressed key did not pull interrupt low");

	busyPoll_a: assert property (
		(state == sesl_pkg::ST_IDLE && csLev) |=> dataOut == !$past(busy))
		else $error("data out does not show busy state");

endmodule // sesl_core

`default_nettype wire

//--- core/sesl_pkg.sv
// Purpose: shared constants and types for the serial memory with switch terminals
// Assumes: 25 MHz core clock, serial link sampled as plain inputs
// Notes: the contract below is kept by the core and its host
//
// Contract
// - four link wires: clock, select, in, out
// - 1K bits storage, eight terminals A/B
// - locations 0-60 via five instructions
// - programming disabled rejects all programming writes
// - write-all stores one word everywhere
// - location 61 holds power-up switch setup
// - power-up copies 61 into control word
// - volatile control word drives all terminals
// - location 63 reads live terminal levels
// - mode code 110x holds switch open
// - mode code 111x holds switch closed
// - mode 0101 gives debounce key arrangement
// - pressed key pulls interrupt line low
// - modes 0-3 drive fixed pair levels
// - mode 0011 drives both outputs high
// - start bit, opcode, address, 16-bit data
// - busy shows low on data out, then high
// - control word write needs no programming

package sesl_pkg;

	// word and address geometry
	localparam int         DATA_W    = 16;
	localparam int         ADDR_W    = 6;
	localparam int         MEM_WORDS = 64;
	localparam logic [5:0] ADDR_ISS  = 6'h3D; // initial_switch_store
	localparam logic [5:0] ADDR_SCW  = 6'h3E; // switch_control_word
	localparam logic [5:0] ADDR_SRW  = 6'h3F; // switch_readback_word

	// command byte fields
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_EXT   = 2'h0;
	localparam logic [1:0] EXT_DIS  = 2'h0; // program_disable_cmd
	localparam logic [1:0] EXT_ALL  = 2'h1; // write_all_cmd
	localparam logic [1:0] EXT_EN   = 2'h3;
	localparam logic [4:0] CMD_LAST  = 5'h07;
	localparam logic [4:0] DATA_LAST = 5'h0F;

	// programming time
	localparam int          CLK_MHZ      = 25;
	localparam int          PROG_TIME_US = 100;
	localparam int          PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
	localparam logic [11:0] PROG_COUNT   = 12'(PROG_CYCLES);

	// start values: erased array word, control word after reset
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [15:0] SCW_RESET   = 16'h8888;

	// terminal_mode_code values
	localparam logic [1:0] MODE_LVL    = 2'h0;
	localparam logic [3:0] MODE_DEB    = 4'h5;
	localparam logic [2:0] MODE_OPEN   = 3'h6;
	localparam logic [2:0] MODE_CLOSED = 3'h7;

	// positions in the synchroniser vector
	localparam int SYNC_DI   = 0;
	localparam int SYNC_CS   = 1;
	localparam int SYNC_SK   = 2;
	localparam int SYNC_TERM = 3;
	localparam int SYNC_W    = 11;
	// idle pin levels: terminals pulled high, link wires low
	localparam logic [10:0] SYNC_IDLE = 11'h7F8;

	typedef enum {
		ST_BOOT, ST_BOOTLD, ST_IDLE, ST_CMD, ST_DIN,
		ST_COMMIT, ST_RDSEL, ST_RDLOAD, ST_DOUT, ST_DONE
	} sesl_state_e;

	// host-driven link wires
	typedef struct packed {
		logic sk;
		logic cs;
		logic di;
	} sesl_link_s;

	// terminal_group_b over terminal_group_a
	typedef struct packed {
		logic [3:0] b;
		logic [3:0] a;
	} sesl_term_s;

endpackage

//--- core/sesl_nv_store.sv
// Purpose: non-volatile word array, one write and one read port
// Assumes: read data registered, one cycle after the address
// Notes: starts erased in simulation, survives the core reset

`timescale 1ns/1ps
`default_nettype none

module sesl_nv_store (
	input  wire logic        clock,
	input  wire logic        we,
	input  wire logic [5:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [5:0]  raddr,
	output var  logic [15:0] rdata
);

	// 64 words of 16 bits
	logic [15:0] cells [sesl_pkg::MEM_WORDS];

	// erased state, stands in for cells never written
	initial begin
		for (int i = 0; i < sesl_pkg::MEM_WORDS; i++) begin
			cells[i] = sesl_pkg::ERASED_WORD;
		end
	end

	// write and registered read; no reset, contents are kept
	always_ff @(posedge clock) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
		rdata <= cells[raddr];
	end

endmodule // sesl_nv_store

`default_nettype wire

//--- dv/sesl_host_model.sv
// Purpose: host end of the four-wire serial link
// Assumes: link clock of 320 ns, edges placed just after core clock edges
// Notes: the link clock stands low outside frames; di is not held after a frame

`timescale 1ns/1ps
`default_nettype none

module sesl_host_model (
	input  wire logic                 clock,
	input  wire logic                 dataOut,
	output var  sesl_pkg::sesl_link_s link
);
	localparam int HALF  = 4;    // core clocks per half link period
	localparam int LIMIT = 4000; // bound on any busy wait

	// idle: deselected, clock low
	initial link = '0;

	// hold one link clock level for half a period
	task automatic hold(input logic level);
		link.sk <= level;
		repeat (HALF) @(posedge clock);
		#1;
	endtask

	// one selected frame of n rises, msb first
	// q collects dataOut just before each rise; the last 16 are the read word
	task automatic frame(input logic [25:0] bits, input int n, output logic [15:0] q);
		q = 16'h0000;
		link.cs <= 1'b1;
		// select settles before the start bit
		hold(1'b0);
		for (int i = n - 1; i >= 0; i--) begin
			link.di <= bits[i];
			hold(1'b0);
			q = {q[14:0], dataOut};
			hold(1'b1);
		end
		// bit 0 was taken before the last rise; no extra sample after it
		hold(1'b0);
		link.cs <= 1'b0;
		// released line flips so a stale bit is never read as valid
		link.di <= ~link.di;
		hold(1'b0);
		hold(1'b0);
	endtask

	// reselect and wait for ready on dataOut, bounded
	task automatic poll(output int waited);
		waited = 0;
		link.cs <= 1'b1;
		while (dataOut !== 1'b1 && waited < LIMIT) begin
			@(posedge clock);
			#1;
			waited++;
		end
		link.cs <= 1'b0;
		hold(1'b0);
		hold(1'b0);
	endtask

endmodule // sesl_host_model

`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for the switch-terminal serial memory
// Assumes: host model drives the link, the bench models the terminal pins
// Notes: programming cycles run at full length, about 2500 clocks each

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic                 clock = 1'b0;   // 25 MHz core clock
	logic                 rst = 1'b1;     // synchronous reset
	logic                 dataOut;        // serial data out
	logic [3:0]           anaClosed;      // analog switch states
	logic [3:0]           keyDown = 4'h0; // keys grounding group a pins
	logic [15:0]          q;              // last word read
	int                   waited;         // clocks until ready
	int                   n_fail = 0;
	int                   checks_done = 0;
	sesl_pkg::sesl_link_s link;
	sesl_pkg::sesl_term_s termIn, termOut, termOe;
	logic [5:0]           addrs [4] = '{6'h00, 6'h1E, 6'h3C, 6'h3D}; // write-all probes

	// half period 20 ns
	always #20 clock = ~clock;

	// pins pulled up; a pressed key grounds its group a pin
	assign termIn = {termOut.b | ~termOe.b, ~keyDown & (termOut.a | ~termOe.a)};

	sesl_core dut (.clock(clock), .rst(rst), .link(link), .termIn(termIn),
		.dataOut(dataOut), .termOut(termOut), .termOe(termOe), .anaClosed(anaClosed));

	sesl_host_model host (.clock(clock), .dataOut(dataOut), .link(link));

	// wait n clocks, land just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// compare and count
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// read instruction: start, opcode, address, dummy plus 16 bits
	task automatic rdchk(input string nm, input logic [5:0] a, input logic [15:0] exp);
		host.frame({1'b1, sesl_pkg::OP_READ, a, 17'h00000}, 26, q);
		chk(nm, q, exp);
	endtask

	// write instruction with one data word
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		host.frame({1'b0, 1'b1, sesl_pkg::OP_WRITE, a, d}, 25, q);
	endtask

	// extended instruction without data
	task automatic ext(input logic [1:0] x);
		host.frame({17'h00000, 1'b1, sesl_pkg::OP_EXT, x, 4'h0}, 9, q);
	endtask

	// ready poll; a bound that runs out ends the run
	task automatic waitReady();
		host.poll(waited);
		if (waited >= 4000) begin
			n_fail++;
			results();
		end
	endtask

	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask

	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence
	initial begin
		tick(20);
		rst = 1'b0;
		tick(8);
		// programming is off after reset
		wr(6'h05, 16'h1234);
		rdchk("refused", 6'h05, 16'hFFFF);
		ext(sesl_pkg::EXT_EN);
		wr(6'h05, 16'h1234);
		waitReady();
		chk("busy", 16'(waited > 2000), 16'h0001);
		rdchk("written", 6'h05, 16'h1234);
		ext(sesl_pkg::EXT_DIS);
		wr(6'h05, 16'h0000);
		rdchk("disabled", 6'h05, 16'h1234);
		done("program guard");
		// one word everywhere, ends included
		ext(sesl_pkg::EXT_EN);
		host.frame({1'b0, 1'b1, sesl_pkg::OP_EXT, sesl_pkg::EXT_ALL, 4'h0, 16'hA5A5}, 25, q);
		waitReady();
		foreach (addrs[i]) rdchk("all", addrs[i], 16'hA5A5);
		done("write all");
		// power-up store copied into the control word by a reset
		wr(sesl_pkg::ADDR_ISS, 16'h355E);
		waitReady();
		rst = 1'b1;
		tick(4);
		rst = 1'b0;
		tick(8);
		rdchk("boot word", sesl_pkg::ADDR_SCW, 16'h355E);
		chk("closed", 16'(anaClosed[0]), 16'h0001);
		chk("pair3", 16'({termOe.a[3], termOe.b[3], termOut.a[3], termOut.b[3]}), 16'h000F);
		done("power-up");
		// every fixed level code on pair 3, programming still off
		for (int k = 0; k < 4; k++) begin
			wr(sesl_pkg::ADDR_SCW, {2'b00, 2'(k), 12'h55E});
			waitReady();
			chk("no busy", 16'(waited < 20), 16'h0001);
			chk("level", 16'({termOe.a[3], termOe.b[3], termOut.a[3], termOut.b[3]}), 16'(12 + k));
		end
		wr(sesl_pkg::ADDR_SCW, 16'h355C);
		tick(2);
		chk("open", 16'(anaClosed[0]), 16'h0000);
		done("modes");
		// key on pair 1 pulls the shared line low
		keyDown = 4'h2;
		tick(10);
		chk("int low", 16'({termOe.b[1], termOut.b[1]}), 16'h0002);
		// debounce delay before reading back
		tick(50);
		rdchk("levels", sesl_pkg::ADDR_SRW, 16'h00DD);
		keyDown = 4'h0;
		tick(10);
		chk("int free", 16'(termOe.b[1]), 16'h0000);
		done("keys");
		// readback location ignores writes
		wr(sesl_pkg::ADDR_SRW, 16'h0000);
		rdchk("readback", sesl_pkg::ADDR_SRW, 16'h00FF);
		rdchk("ctl kept", sesl_pkg::ADDR_SCW, 16'h355C);
		// select dropped in mid-data: nothing written
		host.frame({11'h000, 1'b1, sesl_pkg::OP_WRITE, sesl_pkg::ADDR_SCW, 6'h00}, 15, q);
		rdchk("aborted", sesl_pkg::ADDR_SCW, 16'h355C);
		done("abort");
		results();
	end

endmodule // tb_top

`default_nettype wire
